//--- hdl/abs_min_pulse.sv
/*
 * Switch gate with guaranteed minimum on and off durations.
 * Assumes the demand comes from logic on the same clock.
 */
`timescale 1ns/1ns
module abs_min_pulse
    import abs_pkg::*;
#(
    parameter int CW = MIN_CNT_W
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          demand,
    input  wire logic [CW-1:0] minOnCyc,
    input  wire logic [CW-1:0] minOffCyc,
    output logic               gate_r
);
    logic [CW-1:0] holdCnt_r;
    logic [CW-1:0] runCnt_r;
    wire           toggle = (holdCnt_r == '0) && (demand != gate_r);
    wire  [CW-1:0] loadCnt = demand ? minOnCyc - 1'b1 : minOffCyc - 1'b1;

    // Run counter needs at least two bits to tell one from saturation
    if (CW < 2) begin : g_bad_param
        $error("abs_min_pulse: counter width too small");
    end

    // ==========================================================
    // Change only once the hold count has run out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_r    <= 1'b0;
            holdCnt_r <= '0;
        end else if (toggle) begin
            gate_r    <= demand;
            holdCnt_r <= loadCnt;
        end else if (holdCnt_r != '0) begin
            holdCnt_r <= holdCnt_r - 1'b1;
        end
    end

    // Run length helper, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runCnt_r <= '0;
        end else if (toggle) begin
            runCnt_r <= {{(CW-1){1'b0}}, 1'b1};
        end else if (runCnt_r != '1) begin
            runCnt_r <= runCnt_r + 1'b1;
        end
    end

    property p_min_on;
        @(posedge clk) disable iff (!resetn)
        $fell(gate_r) |-> ($past(runCnt_r) >= $past(minOnCyc));
    endproperty
    a_min_on: assert property (p_min_on) else $error("switch on time too short");

    property p_min_off;
        @(posedge clk) disable iff (!resetn)
        $rose(gate_r) && ($past(runCnt_r) != '1) |-> ($past(runCnt_r) >= $past(minOffCyc));
    endproperty
    a_min_off: assert property (p_min_off) else $error("switch off time too short");
endmodule : abs_min_pulse

//--- hdl/abs_pkg.sv
/*
 * Constants, timing counts and state encoding for the adaptive boost supervisor.
 * Assumes a single 25 MHz core clock and an asynchronous active-low reset.
 */
package abs_pkg;

    // ==========================================================
    // Clock
    localparam int CLK_MHZ       = 25;
    localparam int CLK_PERIOD_NS = 40;

    // ==========================================================
    // Switch minimum times (least times, rounded up)
    localparam int MIN_OFF_LO_NS  = 150;
    localparam int MIN_ON_LO_NS   = 150;
    localparam int MIN_OFF_HI_NS  = 40;
    localparam int MIN_ON_HI_NS   = 110;
    localparam int MIN_OFF_LO_CYC = (MIN_OFF_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ON_LO_CYC  = (MIN_ON_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_HI_CYC = (MIN_OFF_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ON_HI_CYC  = (MIN_ON_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_CNT_W      = 3;

    // ==========================================================
    // Undervoltage timeout and recovery hold
    localparam int UV_TIMEOUT_MS  = 110;
    localparam int UV_TIMEOUT_CYC = UV_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int RECOVER_MS     = 100;
    localparam int RECOVER_CYC    = RECOVER_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Feedback thresholds, in millivolts at the feedback node
    localparam int VREF_MV     = 1210;
    localparam int OVPL_MV     = 1423;
    localparam int OVPH_MV     = 1760;
    localparam int UVP_MV      = 886;
    localparam int MV_PER_LSB  = 2;
    localparam int OVL_OFS     = (OVPL_MV - VREF_MV) / MV_PER_LSB;
    localparam int OVH_OFS     = (OVPH_MV - VREF_MV) / MV_PER_LSB;
    localparam int UV_OFS      = (VREF_MV - UVP_MV) / MV_PER_LSB;

    // ==========================================================
    // Adaptive loop defaults
    localparam int TGT_W_DEF   = 10;
    localparam int INIT_PCT    = 88;
    localparam int SAMPLE_CYC  = 256;
    localparam int STEP_DEF    = 1;
    localparam int NUM_SINKS   = 6;
    localparam int STRAP_WAIT  = 3;

    // ==========================================================
    // Supervisor states
    typedef enum logic [1:0] {
        ST_STRAP   = 2'b00,
        ST_START   = 2'b01,
        ST_ADAPT   = 2'b10,
        ST_RECOVER = 2'b11
    } abs_state_e;

endpackage : abs_pkg

//--- hdl/abs_supervisor.sv
/*
 * Adaptive boost supervisor: boost target loop, fault thresholds, switch gating.
 * Assumes feedback code, sink faults, channel enable and switch demand come
 * from logic on this clock; comparator and strap pins are asynchronous.
 */
`timescale 1ns/1ns
module abs_supervisor
    import abs_pkg::*;
#(
    parameter int TGT_W          = TGT_W_DEF,
    parameter int STEP           = STEP_DEF,
    parameter int SAMPLE_PERIOD  = SAMPLE_CYC,
    parameter int UV_TIMEOUT     = UV_TIMEOUT_CYC,
    parameter int RECOVER_PERIOD = RECOVER_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [2:0]           stringCountSelect,
    input  wire logic                 highBand,
    input  wire logic                 channelsActive,
    input  wire logic [NUM_SINKS-1:0] sinkBelowHeadroom,
    input  wire logic [NUM_SINKS-1:0] sinkNearHeadroom,
    input  wire logic [NUM_SINKS-1:0] sinkFault,
    input  wire logic [TGT_W-1:0]     fbCode,
    input  wire logic                 switchDemand,
    input  wire logic [2:0]           flagClear,
    output logic                      switchGate,
    output logic [TGT_W-1:0]          boostTarget,
    output logic [TGT_W:0]            overvoltLowLevel,
    output logic [TGT_W:0]            overvoltHighLevel,
    output logic [TGT_W:0]            undervoltLevel,
    output logic                      boostOvervoltLowFlag,
    output logic                      boostOvervoltHighFlag,
    output logic                      boostUndervoltTimeoutFlag,
    output logic                      faultRecovery,
    output logic [NUM_SINKS-1:0]      sinksInUse
);
    // ==========================================================
    // Derived constants and elaboration checks
    localparam int TMR_MAX = (UV_TIMEOUT > RECOVER_PERIOD) ? UV_TIMEOUT : RECOVER_PERIOD;
    localparam int TMR_W   = $clog2(TMR_MAX + 1);
    localparam int SMP_W   = $clog2(SAMPLE_PERIOD + 1);
    localparam int TGT_TOP = (1 << TGT_W) - 1;
    localparam logic [TGT_W-1:0] TGT_MAX  = TGT_W'(TGT_TOP);
    localparam logic [TGT_W-1:0] TGT_INIT = TGT_W'((TGT_TOP * INIT_PCT) / 100);
    localparam logic [TGT_W:0]   STEP_V   = (TGT_W+1)'(STEP);
    localparam logic [TGT_W:0]   OVL_V    = (TGT_W+1)'(OVL_OFS);
    localparam logic [TGT_W:0]   OVH_V    = (TGT_W+1)'(OVH_OFS);
    localparam logic [TGT_W:0]   UV_V     = (TGT_W+1)'(UV_OFS);

    if (STEP < 1 || STEP > TGT_TOP || SAMPLE_PERIOD < 1 || UV_TIMEOUT < 2 ||
        RECOVER_PERIOD < 1 || TGT_W < 9 || TGT_W > 16) begin : g_bad_param
        $error("abs_supervisor: unsupported parameter value");
    end

    // ==========================================================
    // Declarations
    abs_state_e                stateR;
    abs_state_e                stateNxt;
    logic [TMR_W-1:0]          tmr_r;
    logic [SMP_W-1:0]          smpCnt_r;
    logic [1:0]                strapCnt_r;
    logic                      highBand_r;
    logic [TGT_W-1:0]          target_nxt;
    logic [NUM_SINKS-1:0]      belowS;
    logic [NUM_SINKS-1:0]      nearS;
    logic [2:0]                selS;
    logic                      bandS;
    logic                      gateW;

    // ==========================================================
    // Pin synchronisers
    abs_sync2 #(.W(2*NUM_SINKS)) u_sinkSync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({sinkNearHeadroom, sinkBelowHeadroom}),
        .dout   ({nearS, belowS})
    );

    abs_sync2 #(.W(4)) u_strapSync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({highBand, stringCountSelect}),
        .dout   ({bandS, selS})
    );

    // ==========================================================
    // Sink selection and loop decisions
    wire [NUM_SINKS-1:0] strapMask = (selS == 3'h0 || selS > 3'h6) ? 6'h3f
                                   : NUM_SINKS'((7'h01 << selS) - 7'h01);
    wire [NUM_SINKS-1:0] monitored = sinksInUse & ~sinkFault;
    wire anyLow     = |(belowS & monitored);
    wire anyNear    = |(nearS & monitored);
    wire sampleTick = (smpCnt_r == SMP_W'(SAMPLE_PERIOD - 1));
    wire stepUp     = sampleTick && anyLow;
    wire stepDown   = sampleTick && (|monitored) && !anyLow && !anyNear;
    wire inRun      = (stateR == ST_START) || (stateR == ST_ADAPT);

    // Saturating up and down targets
    wire [TGT_W:0] tgtWide = {1'b0, boostTarget};
    wire [TGT_W:0] upSum   = tgtWide + STEP_V;
    wire [TGT_W-1:0] tgtUp   = (upSum > {1'b0, TGT_MAX}) ? TGT_MAX : upSum[TGT_W-1:0];
    wire [TGT_W-1:0] tgtDown = (tgtWide < STEP_V) ? '0 : boostTarget - STEP_V[TGT_W-1:0];

    // ==========================================================
    // Fault comparisons against tracking thresholds
    wire [TGT_W:0] fbWide   = {1'b0, fbCode};
    wire ovLowNow   = fbWide >= overvoltLowLevel;
    wire ovHighNow  = fbWide >= overvoltHighLevel;
    wire uvNow      = fbWide < undervoltLevel;
    wire uvExpire   = inRun && uvNow && (tmr_r == TMR_W'(UV_TIMEOUT - 1));
    wire recDone    = (stateR == ST_RECOVER) && (tmr_r == TMR_W'(RECOVER_PERIOD - 1));
    wire runFault   = inRun && (ovHighNow || uvExpire);
    wire allowSw    = inRun && !ovLowNow;

    // Minimum times follow the sampled frequency band
    wire [MIN_CNT_W-1:0] minOn  = highBand_r ? MIN_CNT_W'(MIN_ON_HI_CYC)
                                             : MIN_CNT_W'(MIN_ON_LO_CYC);
    wire [MIN_CNT_W-1:0] minOff = highBand_r ? MIN_CNT_W'(MIN_OFF_HI_CYC)
                                             : MIN_CNT_W'(MIN_OFF_LO_CYC);

    abs_min_pulse #(.CW(MIN_CNT_W)) u_gate (
        .clk       (clk),
        .resetn    (resetn),
        .demand    (switchDemand && allowSw),
        .minOnCyc  (minOn),
        .minOffCyc (minOff),
        .gate_r    (gateW)
    );
    assign switchGate = gateW;

    // ==========================================================
    // Next state and next target
    always_comb begin
        stateNxt   = stateR;
        target_nxt = boostTarget;
        case (stateR)
            ST_STRAP: begin
                if (strapCnt_r == 2'(STRAP_WAIT)) begin
                    stateNxt = ST_START;
                end
            end
            ST_START: begin
                target_nxt = TGT_INIT;
                if (runFault) begin
                    stateNxt = ST_RECOVER;
                end else if (channelsActive) begin
                    stateNxt = ST_ADAPT;
                end
            end
            ST_ADAPT: begin
                if (runFault) begin
                    stateNxt = ST_RECOVER;
                end else if (!channelsActive) begin
                    stateNxt   = ST_START;
                    target_nxt = TGT_INIT;
                end else if (stepUp) begin
                    target_nxt = tgtUp;
                end else if (stepDown) begin
                    target_nxt = tgtDown;
                end
            end
            ST_RECOVER: begin
                target_nxt = TGT_INIT;
                if (recDone) begin
                    stateNxt = ST_START;
                end
            end
            default: begin
                stateNxt = ST_STRAP;
            end
        endcase
    end

    // ==========================================================
    // State, target and straps; strap pins are read in the strap state only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateR      <= ST_STRAP;
            boostTarget <= TGT_INIT;
            strapCnt_r  <= 2'h0;
            sinksInUse  <= '0;
            highBand_r  <= 1'b0;
        end else begin
            stateR      <= stateNxt;
            boostTarget <= target_nxt;
            if (stateR == ST_STRAP) begin
                strapCnt_r <= strapCnt_r + 2'h1;
                sinksInUse <= strapMask;
                highBand_r <= bandS;
            end
        end
    end

    // Shared timer: undervolt wait in run states, hold in recovery
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_r <= '0;
        end else if (stateNxt != stateR || (inRun && !uvNow)) begin
            tmr_r <= '0;
        end else if (inRun || stateR == ST_RECOVER) begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    // Sample period counter, free running in adapt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            smpCnt_r <= '0;
        end else if (stateR != ST_ADAPT || sampleTick) begin
            smpCnt_r <= '0;
        end else begin
            smpCnt_r <= smpCnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Tracking thresholds; one cycle behind the target
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overvoltLowLevel  <= '1;
            overvoltHighLevel <= '1;
            undervoltLevel    <= '0;
        end else begin
            overvoltLowLevel  <= tgtWide + OVL_V;
            overvoltHighLevel <= tgtWide + OVH_V;
            undervoltLevel    <= (tgtWide < UV_V) ? '0 : tgtWide - UV_V;
        end
    end

    // ==========================================================
    // Sticky fault flags, a new event beats a clear in the same cycle; faultRecovery follows the next state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boostOvervoltLowFlag      <= 1'b0;
            boostOvervoltHighFlag     <= 1'b0;
            boostUndervoltTimeoutFlag <= 1'b0;
            faultRecovery             <= 1'b0;
        end else begin
            boostOvervoltLowFlag      <= (inRun && ovLowNow) ||
                                         (boostOvervoltLowFlag && !flagClear[0]);
            boostOvervoltHighFlag     <= (inRun && ovHighNow) ||
                                         (boostOvervoltHighFlag && !flagClear[1]);
            boostUndervoltTimeoutFlag <= uvExpire ||
                                         (boostUndervoltTimeoutFlag && !flagClear[2]);
            faultRecovery             <= (stateNxt == ST_RECOVER);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_init_hold;
        stateR == ST_START |-> boostTarget == TGT_INIT;
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("start level wrong");

    property p_wait_active;
        stateR == ST_START && !channelsActive |=> stateR != ST_ADAPT;
    endproperty
    a_wait_active: assert property (p_wait_active) else $error("adapt too early");

    property p_step_up;
        stateR == ST_ADAPT && stateNxt == ST_ADAPT && stepUp && boostTarget != TGT_MAX
        |=> boostTarget > $past(boostTarget);
    endproperty
    a_step_up: assert property (p_step_up) else $error("target not raised");

    property p_step_down;
        stateR == ST_ADAPT && stateNxt == ST_ADAPT && sampleTick && (|monitored) &&
        ((belowS | nearS) & monitored) == '0 && boostTarget >= TGT_W'(STEP)
        |=> boostTarget == $past(boostTarget) - TGT_W'(STEP);
    endproperty
    a_step_down: assert property (p_step_down) else $error("target not lowered");

    property p_unused_ignored;
        stateR == ST_ADAPT && sampleTick && (belowS & sinksInUse) == '0 && stateNxt == ST_ADAPT
        |=> boostTarget <= $past(boostTarget);
    endproperty
    a_unused_ignored: assert property (p_unused_ignored) else $error("unused sink raised");

    property p_fault_excluded;
        stateR == ST_ADAPT && stateNxt == ST_ADAPT && sampleTick &&
        (belowS & sinksInUse & ~sinkFault) == '0
        |=> boostTarget <= $past(boostTarget);
    endproperty
    a_fault_excluded: assert property (p_fault_excluded) else $error("faulted sink used");

    property p_ovl_stop;
        ovLowNow [*6] |-> !switchGate;
    endproperty
    a_ovl_stop: assert property (p_ovl_stop) else $error("switching under overvolt");

    property p_ovh_recover;
        inRun && ovHighNow |=> stateR == ST_RECOVER && boostOvervoltHighFlag;
    endproperty
    a_ovh_recover: assert property (p_ovh_recover) else $error("no overvolt recovery");

    property p_uv_start;
        inRun && !uvNow ##1 inRun && uvNow && stateNxt == stateR |=> tmr_r == TMR_W'(1);
    endproperty
    a_uv_start: assert property (p_uv_start) else $error("uv timer not started");

    property p_uv_expire;
        uvExpire |=> stateR == ST_RECOVER && boostUndervoltTimeoutFlag;
    endproperty
    a_uv_expire: assert property (p_uv_expire) else $error("uv timeout missed");

    property p_track;
        1'b1 |=> overvoltHighLevel == $past(tgtWide) + OVH_V &&
                 overvoltLowLevel == $past(tgtWide) + OVL_V;
    endproperty
    a_track: assert property (p_track) else $error("threshold not tracking");

    property p_strap_once;
        stateR != ST_STRAP |=> $stable(sinksInUse);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("string count changed");
endmodule : abs_supervisor

//--- hdl/abs_sync2.sv
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; multi-bit coherence is not kept.
 */
`timescale 1ns/1ns
module abs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // A zero-width bundle has nothing to carry
    if (W < 1) begin : g_bad_param
        $error("abs_sync2: width must be at least one");
    end

    // ==========================================================
    // First stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : abs_sync2

//--- tb/abs_stage_model.sv
/*
 * Behavioural model of the boost power stage and the LED sink strings.
 * Assumes the bench sets the string voltage need, load mask and feedback offset.
 */
`timescale 1ns/1ns
module abs_stage_model (
    input  wire logic        [9:0]  boostTarget,
    input  wire logic        [9:0]  needCode,
    input  wire logic        [5:0]  loadMask,
    input  wire logic signed [11:0] fbOfs,
    output logic             [5:0]  sinkBelow,
    output logic             [5:0]  sinkNear,
    output logic             [9:0]  fbCode
);
    logic signed [12:0] fbSum;

    // ==========================================================
    // Headroom: a loaded string sags when the target is under its need
    assign sinkBelow = (boostTarget < needCode) ? loadMask : 6'h00;
    assign sinkNear  = ({1'b0, boostTarget} <= {1'b0, needCode} + 11'h001) ? loadMask : 6'h00;
    // Output follows the target plus an offset; clamped, the stage cannot exceed code range
    assign fbSum  = $signed({3'h0, boostTarget}) + 13'(fbOfs);
    assign fbCode = (fbSum < 0) ? 10'h000 : (fbSum > 13'sh3ff) ? 10'h3ff : fbSum[9:0];
endmodule : abs_stage_model

//--- tb/abs_supervisor_tb_top.sv
/*
 * Self-checking bench for the adaptive boost supervisor, one task per scenario.
 * Assumes abs_pkg and the stage model; timers shortened through parameters.
 */
`timescale 1ns/1ns
module abs_supervisor_tb_top
    import abs_pkg::*;
;
    localparam int SP = 8;
    logic               clk, resetn, highBand, channelsActive, switchDemand;
    logic               switchGate, fL, fH, fU, faultRecovery;
    logic        [2:0]  stringCountSelect, flagClear;
    logic        [5:0]  sinkFault, loadMask, sinkBelow, sinkNear, sinksInUse;
    logic        [9:0]  fbCode, boostTarget, needCode, t0;
    logic        [10:0] ovL, ovH, uvL;
    logic signed [11:0] fbOfs;
    int                 n_fail = 0, n_checks = 0, n, k, m;

    // ==========================================================
    // Design and far side
    abs_supervisor #(.UV_TIMEOUT(20), .RECOVER_PERIOD(10), .SAMPLE_PERIOD(SP)) uut (
        .clk(clk), .resetn(resetn), .stringCountSelect(stringCountSelect),
        .highBand(highBand), .channelsActive(channelsActive),
        .sinkBelowHeadroom(sinkBelow), .sinkNearHeadroom(sinkNear), .sinkFault(sinkFault),
        .fbCode(fbCode), .switchDemand(switchDemand), .flagClear(flagClear),
        .switchGate(switchGate), .boostTarget(boostTarget), .overvoltLowLevel(ovL),
        .overvoltHighLevel(ovH), .undervoltLevel(uvL), .boostOvervoltLowFlag(fL),
        .boostOvervoltHighFlag(fH), .boostUndervoltTimeoutFlag(fU),
        .faultRecovery(faultRecovery), .sinksInUse(sinksInUse));
    abs_stage_model stage (
        .boostTarget(boostTarget), .needCode(needCode), .loadMask(loadMask),
        .fbOfs(fbOfs), .sinkBelow(sinkBelow), .sinkNear(sinkNear), .fbCode(fbCode));

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks; inputs always move 5 ns after the edge
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #5;
    endtask : cyc
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // Bounded wait; a hang ends the run rather than stalling it
    task automatic waitv(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (s !== v) begin
            chk("wait", 12'(v), 12'(s));
            test_done();
        end
    endtask : waitv
    // Straps must be stable before release, so they are set inside reset
    task automatic doReset(input logic hb, input logic [2:0] sel);
        resetn = 1'b0;
        highBand = hb;
        stringCountSelect = sel;
        cyc(5);
        resetn = 1'b1;
        cyc(8);
    endtask : doReset

    // ==========================================================
    // Scenarios
    task automatic sGate(input int mOn, input int mOff);
        switchDemand = 1'b1;
        waitv(switchGate, 1'b1, 10);
        switchDemand = 1'b0;
        waitv(switchGate, 1'b0, 20);
        k = n;
        switchDemand = 1'b1;
        waitv(switchGate, 1'b1, 20);
        m = n;
        switchDemand = 1'b0;
        chk("minOn", 12'h001, 12'(k >= mOn));
        chk("minOff", 12'h001, 12'(m >= mOff && m < 20));
        cyc(8);
    endtask : sGate
    // Loop must stay parked before the sinks run, then climb once they do
    task automatic sStartUp();
        chk("inUse", 12'h00f, 12'(sinksInUse));
        chk("ovL", 12'h3ee, 12'(ovL));
        chk("ovH", 12'h497, 12'(ovH));
        chk("uvL", 12'h2e2, 12'(uvL));
        loadMask = 6'h01;
        needCode = 10'h3ff;
        cyc(SP * 4);
        chk("init", 12'h384, 12'(boostTarget));
        channelsActive = 1'b1;
        cyc(SP * 10);
        sinkFault = 6'h3f;
        cyc(4);
        chk("up", 12'h001, 12'(boostTarget > 10'h384));
        chk("ovLtrk", {2'h0, boostTarget} + 12'h06a, 12'(ovL));
        chk("uvLtrk", {2'h0, boostTarget} - 12'h0a2, 12'(uvL));
    endtask : sStartUp
    // A sagging string that must be ignored may not hold the target up
    task automatic sDrop(input logic [5:0] mask, input logic [5:0] flt);
        loadMask = mask;
        sinkFault = flt;
        t0 = boostTarget;
        cyc(SP * 5);
        chk("drop", 12'h001, 12'(boostTarget < t0));
    endtask : sDrop
    task automatic sSettle();
        loadMask = 6'h01;
        sinkFault = 6'h00;
        needCode = 10'h258;
        for (k = 0; boostTarget !== 10'h259 && k < 4000; k++) cyc(1);
        if (boostTarget !== 10'h259) begin
            chk("settleWait", 12'h259, 12'(boostTarget));
            test_done();
        end
        cyc(SP * 5);
        chk("settle", 12'h259, 12'(boostTarget));
    endtask : sSettle
    task automatic sOvLow();
        sinkFault = 6'h3f;
        switchDemand = 1'b1;
        fbOfs = 12'sh069;
        cyc(6);
        chk("ovlEdge", 12'h001, 12'({switchGate, fL} == 2'b10));
        fbOfs = 12'sh06a;
        cyc(6);
        chk("ovlHit", 12'h002, 12'({switchGate, fL, faultRecovery}));
        fbOfs = 12'sh000;
        cyc(6);
        chk("resume", 12'h001, 12'(switchGate));
        flagClear = 3'h1;
        cyc(1);
        flagClear = 3'h0;
        cyc(1);
        chk("ovlClr", 12'h000, 12'(fL));
        switchDemand = 1'b0;
    endtask : sOvLow
    task automatic sOvHigh();
        fbOfs = 12'sh112;
        cyc(4);
        chk("ovhEdge", 12'h000, 12'({fH, faultRecovery}));
        // Overvolt-low still stands here, so its event must beat the clear
        flagClear = 3'h1;
        cyc(1);
        flagClear = 3'h0;
        chk("ovlSetWins", 12'h001, 12'(fL));
        fbOfs = 12'sh113;
        waitv(faultRecovery, 1'b1, 4);
        chk("ovhHit", 12'h002, 12'({fH, switchGate}));
        fbOfs = 12'sh000;
        waitv(faultRecovery, 1'b0, 30);
        chk("recTgt", 12'h384, 12'(boostTarget));
    endtask : sOvHigh
    task automatic sUnder();
        fbOfs = -12'sh0a2;
        cyc(30);
        fbOfs = -12'sh0a3;
        cyc(12);
        fbOfs = 12'sh000;
        cyc(30);
        chk("uvShort", 12'h000, 12'({fU, faultRecovery}));
        fbOfs = -12'sh0a3;
        waitv(faultRecovery, 1'b1, 40);
        chk("uvTime", 12'h001, 12'(n >= 20));
        chk("uvFlag", 12'h001, 12'(fU));
        fbOfs = 12'sh000;
        waitv(faultRecovery, 1'b0, 30);
        flagClear = 3'h6;
        cyc(1);
        flagClear = 3'h0;
        cyc(1);
        chk("hiUvClr", 12'h000, 12'({fH, fU}));
    endtask : sUnder

    // ==========================================================
    // Main sequence
    initial begin
        {resetn, highBand, channelsActive, switchDemand} = 4'h0;
        stringCountSelect = 3'h4;
        flagClear = 3'h0;
        {sinkFault, loadMask} = 12'h000;
        needCode = 10'h000;
        fbOfs = 12'sh000;
        doReset(1'b0, 3'h4);
        sGate(4, 4);
        sStartUp();
        sDrop(6'h20, 6'h00);
        sDrop(6'h01, 6'h01);
        sSettle();
        sOvLow();
        sOvHigh();
        sUnder();
        doReset(1'b1, 3'h0);
        chk("inUse6", 12'h03f, 12'(sinksInUse));
        sGate(3, 1);
        test_done();
    end
endmodule : abs_supervisor_tb_top
